// File: dv/io_pad_model.sv
`timescale 1ns/10ps
module io_pad_model (
  input  wire  [39:0] pin_out,     // device drive level
  input  wire  [39:0] pin_oe_n,    // device drive enable, active low
  input  wire  [39:0] strong_up_n, // device strong pull-up, active low
  input  wire  [39:0] ext_en,      // external driver on
  input  wire  [39:0] ext_lvl,     // external driver level
  output logic [39:0] pin_in       // resolved pad level
);
  always_comb begin
    for (int i = 0; i < 40; i++) begin
      if (!pin_oe_n[i])
        pin_in[i] = pin_out[i] | ~strong_up_n[i];
      else if (ext_en[i])
        pin_in[i] = ext_lvl[i]; // an external sink overpowers the weak pull-ups
      else
        pin_in[i] = 1'b1;
    end
  end
endmodule // io_pad_model

// File: dv/io_port_checker_sva.sv
`timescale 1ns/10ps
module io_port_checker (
  input wire        hclk,        // bus clock
  input wire        hresetn,     // reset, active low
  input wire [31:0] hrdata,      // read data
  input wire        hreadyout,   // slave ready
  input wire        hresp,       // response
  input wire [39:0] pin_in,      // pad levels
  input wire [39:0] alt_in,      // alternate inputs
  input wire [39:0] pin_out,     // pad drive level
  input wire [39:0] pin_oe_n,    // drive enable, active low
  input wire [39:0] strong_up_n, // strong pull-up, active low
  input wire [39:0] weak_up,     // weak pull-up
  input wire [39:0] vweak_up,    // very weak pull-up
  input wire [39:0] gpio_free,   // free pins
  input wire [5:0]  gpio_count   // free pin count
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // pad held low long enough to pass the input filter
  sequence s_low(int i);
    !pin_in[i] [*8];
  endsequence
  sequence s_rise(int i);
    $fell(strong_up_n[i]) && vweak_up[i];
  endsequence
  property p_bus;
    hreadyout && !hresp;
  endproperty
  property p_count;
    $past(hresetn) && $stable(gpio_free) |-> gpio_count == 6'($countones(gpio_free));
  endproperty
  property p_fight(int i);
    !pin_oe_n[i] && !pin_out[i] |-> strong_up_n[i] && !weak_up[i] && !vweak_up[i];
  endproperty
  property p_float(int i);
    pin_oe_n[i] |-> strong_up_n[i] && !pin_out[i];
  endproperty
  property p_pulse(int i);
    s_rise(i) |=> strong_up_n[i];
  endproperty
  property p_weak(int i);
    s_low(i) |-> !weak_up[i];
  endproperty
  property p_alt(int i);
    s_low(i) |-> !alt_in[i];
  endproperty
  a_bus: assert property (p_bus)
    else $error("bus reply not zero-wait okay");
  a_count: assert property (p_count)
    else $error("pin count differs from free pins");
  for (genvar i = 0; i < 40; i++) begin : g_pin
    a_fight: assert property (p_fight(i))
      else $error("pull-up on while pulled down");
    a_float: assert property (p_float(i))
      else $error("strong drive while released");
    a_pulse: assert property (p_pulse(i))
      else $error("strong pull-up longer than one clock");
    a_weak: assert property (p_weak(i))
      else $error("weak pull-up on with pin low");
    a_alt: assert property (p_alt(i))
      else $error("alternate input high with pin low");
  end
endmodule // io_port_checker
bind io_port_mode_config io_port_checker chk (
  .hclk(hclk), .hresetn(hresetn), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .pin_in(pin_in), .alt_in(alt_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
  .strong_up_n(strong_up_n), .weak_up(weak_up), .vweak_up(vweak_up),
  .gpio_free(gpio_free), .gpio_count(gpio_count)
);

// File: dv/io_port_mode_config_tb.sv
`timescale 1ns/10ps
`include "io_port_defines.vh"
module io_port_mode_config_tb;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        tristate_fuse = 1'b0, first_osc_enable = 1'b1, ext_mem_used = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
  logic [1:0]  htrans = 2'b00, first_osc_mode = 2'b00, second_osc_pins = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [7:0]  kbd_enable = 8'h00;
  logic [39:0] ext_en = 40'h00_0000_0000, ext_lvl = 40'h00_0000_0000;
  logic [39:0] alt_out = 40'hff_ffff_ffff;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp;
  wire  [39:0] pin_in, alt_in, pin_out, pin_oe_n, strong_up_n, weak_up, vweak_up, gpio_free;
  wire  [5:0]  gpio_count;
  int          fails = 0, n_checks = 0, n;
  localparam logic [79:0] maddr = {`ADDR_PORT0_MODE_SEL_A, `ADDR_PORT0_MODE_SEL_B,
    `ADDR_PORT1_MODE_SEL_A, `ADDR_PORT1_MODE_SEL_B, `ADDR_PORT2_MODE_SEL_A,
    `ADDR_PORT2_MODE_SEL_B, `ADDR_PORT3_MODE_SEL_A, `ADDR_PORT3_MODE_SEL_B,
    `ADDR_PORT4_MODE_SEL_A, `ADDR_PORT4_MODE_SEL_B};
  localparam logic [79:0] rst_on = {8'hff, 8'hff, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff,
    8'h00, 8'hcf, 8'h03};
  localparam logic [79:0] rst_off = {8'hff, 8'hff, 8'h00, 8'h00, 8'hf0, 8'h00, 8'h00,
    8'h00, 8'h03, 8'h03};

  io_port_mode_config #(.ANALOG_PINS_P0(8'h00), .ANALOG_PINS_P2(8'hf0)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .tristate_fuse(tristate_fuse),
    .first_osc_mode(first_osc_mode), .first_osc_enable(first_osc_enable),
    .second_osc_pins(second_osc_pins), .ext_mem_used(ext_mem_used), .kbd_enable(kbd_enable),
    .pin_in(pin_in), .alt_out(alt_out), .alt_in(alt_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .strong_up_n(strong_up_n), .weak_up(weak_up), .vweak_up(vweak_up),
    .gpio_free(gpio_free), .gpio_count(gpio_count));
  io_pad_model pads (
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .strong_up_n(strong_up_n), .ext_en(ext_en),
    .ext_lvl(ext_lvl), .pin_in(pin_in));

  always #12.5 hclk = ~hclk;

  task results;
    if (fails == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    chk({32'h0000_0000, got}, {32'h0000_0000, exp});
  endtask
  // one edge with ready sampled high ends a bus phase
  task wait_rdy;
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 50) begin
        fails++;
        results();
      end
      @(posedge hclk);
    end
  endtask
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {22'h0_0000, a, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, {24'h00_0000, d}, r);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    chk({8'h00, r}, {8'h00, e});
  endtask
  // pads lag the registers by the filter and two flops
  task settle;
    repeat (12) @(posedge hclk);
  endtask
  task do_reset(input logic fuse);
    hresetn <= 1'b0;
    tristate_fuse <= fuse;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask

  initial begin
    for (int f = 1; f >= 0; f--) begin
      do_reset(f[0]);
      for (int k = 0; k < 10; k++)
        rd(maddr[79-8*k -: 8],
           {24'h00_0000, f ? rst_on[79-8*k -: 8] : rst_off[79-8*k -: 8]});
      rd(`ADDR_LATCH_READBACK, 32'hffff_ffff);
      rd(`ADDR_AUX_CONTROL, 32'h0000_0000);
      settle();
      chk({8'h00, pin_oe_n[31:0]}, 40'h00_ffff_ffff);
      chk({8'h00, weak_up[31:0]}, f ? 40'h00_0000_0000 : 40'h00_ff0f_ff00);
      chk({8'h00, vweak_up[31:0]}, f ? 40'h00_0000_0000 : 40'h00_ff0f_ff00);
    end
    wr(8'h84, 8'hff);
    rd(8'h84, 32'h0000_0000);
    // port 1 pins 0..3 in the four modes, the rest quasi
    wr(`ADDR_PORT1_MODE_SEL_A, 8'h0c);
    wr(`ADDR_PORT1_MODE_SEL_B, 8'h0a);
    wr(`ADDR_PORT1_LATCH, 8'h00);
    settle();
    chk8(pin_oe_n[15:8], 8'h04);
    chk8(pin_out[15:8] | weak_up[15:8] | vweak_up[15:8], 8'h00);
    wr(`ADDR_PORT1_LATCH, 8'hff);
    n = 0;
    repeat (12) begin
      @(posedge hclk);
      n += (strong_up_n[8] === 1'b0);
    end
    chk8(8'(n), 8'h01);
    settle();
    chk8(pin_oe_n[15:8], 8'hfd);
    chk8(strong_up_n[15:8], 8'hfd);
    chk8(vweak_up[15:8], 8'hf1);
    chk8(weak_up[15:8], 8'hf1);
    ext_en[12] <= 1'b1;
    settle();
    chk8(weak_up[15:8], 8'he1);
    chk8(vweak_up[15:8], 8'hf1);
    chk8(alt_in[15:8], 8'hef);
    rd(`ADDR_PORT1_LATCH, 32'h0000_00ef);
    rd(`ADDR_LATCH_READBACK, 32'hffff_ffff);
    wr(`ADDR_AUX_CONTROL, 8'h01);
    settle();
    chk(vweak_up, 40'h00_0000_0000);
    chk8(weak_up[15:8], 8'he1);
    kbd_enable <= 8'h01;
    wr(`ADDR_AUX_CONTROL, 8'h03);
    settle();
    rd(`ADDR_PORT1_LATCH, 32'h0000_0001);
    rd(`ADDR_PORT3_LATCH, 32'h0000_000c);
    rd(`ADDR_PORT4_LATCH, 32'h0000_00c0);
    wr(`ADDR_AUX_CONTROL, 8'h00);
    for (int m = 0; m < 3; m++) begin
      first_osc_mode <= 2'(m);
      settle();
      chk8({2'b00, gpio_count}, 8'(38 + m));
      rd(`ADDR_IO_STATUS, 32'(38 + m));
    end
    first_osc_mode <= `OSC_CRYSTAL;
    first_osc_enable <= 1'b0;
    settle();
    chk8({2'b00, gpio_count}, 8'd38);
    first_osc_mode <= `OSC_INTERNAL_RC;
    second_osc_pins <= 2'd2;
    wr(`ADDR_AUX_CONTROL, 8'h04);
    settle();
    chk8({2'b00, gpio_count}, 8'd38);
    wr(`ADDR_AUX_CONTROL, 8'h00);
    settle();
    chk8({2'b00, gpio_count}, 8'd40);
    ext_mem_used <= 1'b1;
    settle();
    chk8({2'b00, gpio_count}, 8'd20);
    results();
  end
endmodule // io_port_mode_config_tb

// File: rtl/io_port_defines.vh
`ifndef IO_PORT_DEFINES_VH
`define IO_PORT_DEFINES_VH
// register indexes; the bus byte address is four times the index
`define ADDR_PORT0_LATCH      8'h80
`define ADDR_PORT1_LATCH      8'h90
`define ADDR_PORT2_LATCH      8'ha0
`define ADDR_PORT3_LATCH      8'hb0
`define ADDR_PORT4_MODE_SEL_A 8'hbe
`define ADDR_PORT4_MODE_SEL_B 8'hbf
`define ADDR_PORT4_LATCH      8'hc0
`define ADDR_PORT3_MODE_SEL_B 8'hcf
`define ADDR_PORT0_MODE_SEL_A 8'hd4
`define ADDR_PORT0_MODE_SEL_B 8'hd5
`define ADDR_PORT2_MODE_SEL_A 8'hd6
`define ADDR_PORT2_MODE_SEL_B 8'hd7
`define ADDR_PORT3_MODE_SEL_A 8'hde
`define ADDR_PORT1_MODE_SEL_A 8'he6
`define ADDR_PORT1_MODE_SEL_B 8'he7
`define ADDR_AUX_CONTROL      8'hf0
`define ADDR_LATCH_READBACK   8'hf4
`define ADDR_IO_STATUS        8'hf8
// auxiliary control field positions
`define AUX_WEAK_PULLUP_OFF   0
`define AUX_POWER_DOWN        1
`define AUX_SECOND_OSC_ENABLE 2
`define AUX_LATCH_PORT_LSB    4
// reset values
`define RST_LATCH             8'hff
`define RST_ALL_ONES          8'hff
`define RST_ALL_ZEROS         8'h00
`define RST_P4_OPEN_DRAIN     8'h03
`define RST_P4_QUASI          8'h30
`define RST_AUX               8'h00
// mode encodings {sel_a, sel_b}
`define MODE_QUASI            2'b00
`define MODE_PUSH_PULL        2'b01
`define MODE_INPUT_ONLY       2'b10
`define MODE_OPEN_DRAIN       2'b11
// first oscillator source codes
`define OSC_CRYSTAL           2'b00
`define OSC_EXT_CLOCK         2'b01
`define OSC_INTERNAL_RC       2'b10
// strong pull-up pulse length in cycles
`define STRONG_PULLUP_CYCLES  1
`endif

// File: rtl/io_port_mode_config.v
// Notes on behaviour
// - two select bits pick each pin mode
// - fuse on: ports 1-3 reset input-only
// - fuse off: ports 1-3 reset quasi-bidirectional, except port 2 analog pins (input-only)
// - port 0 fixed reset modes, port 4 reset modes set by fuse
// - latch zero drives strong pull-down
// - very weak pull-up follows latch one
// - global bit kills very weak pull-ups
// - weak pull-up needs latch and pin high
// - strong pull-up one clock on rise
// - input-only tristates every driver
// - open-drain pulls low only
// - push-pull drives both levels strongly
// - power-down gates most input buffers
// - keyboard pins stay awake in power-down
// - analog pins reset input-only always
// - second oscillator off frees its pins
// - first oscillator pins both free only RC, ext clock frees pin 39
// - free pin count follows clock source
// - plain reads see pins, rmw latch of ports 0-3
// - alternate inputs ANDed with latch unless input-only, outputs with strong pull-up
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/10ps
`include "io_port_defines.vh"
module io_port_mode_config #(
  parameter [7:0] ANALOG_PINS_P0 = 8'hff, // port 0 pins with analog inputs
  parameter [7:0] ANALOG_PINS_P2 = 8'hf0  // port 2 pins with analog inputs
) (
  input  wire        hclk,            // bus clock, 40 MHz
  input  wire        hresetn,         // async reset, active low
  input  wire        hsel,            // slave select
  input  wire [31:0] haddr,           // byte address
  input  wire [1:0]  htrans,          // transfer type
  input  wire        hwrite,          // write strobe
  input  wire [2:0]  hsize,           // transfer size
  input  wire        hready,          // bus ready in
  input  wire [31:0] hwdata,          // write data
  output reg  [31:0] hrdata,          // read data
  output reg         hreadyout,       // slave ready
  output reg         hresp,           // response, always okay
  input  wire        tristate_fuse,   // fuse strap, high = input-only default
  input  wire [1:0]  first_osc_mode,  // first oscillator source
  input  wire        first_osc_enable, // first oscillator enable
  input  wire [1:0]  second_osc_pins, // pins used by the second oscillator
  input  wire        ext_mem_used,    // external memory access active
  input  wire [7:0]  kbd_enable,      // port 1 keyboard input enables
  input  wire [39:0] pin_in,          // pad levels, port 4 at the top
  input  wire [39:0] alt_out,         // alternate function outputs
  output reg  [39:0] alt_in,          // alternate function inputs
  output reg  [39:0] pin_out,         // pad drive level, low when pulled down
  output reg  [39:0] pin_oe_n,        // pad strong drive enable, active low
  output reg  [39:0] strong_up_n,     // strong pull-up enable, active low
  output reg  [39:0] weak_up,         // weak pull-up enable
  output reg  [39:0] vweak_up,        // very weak pull-up enable
  output reg  [39:0] gpio_free,       // pin available as general i/o
  output reg  [5:0]  gpio_count       // number of general i/o pins
);
  localparam ST_IDLE  = 2'b01;
  localparam ST_WRITE = 2'b10;

  reg  [7:0]  latch_r [0:4];
  reg  [7:0]  mode_a_r [0:4];
  reg  [7:0]  mode_b_r [0:4];
  reg  [7:0]  aux_r;
  reg  [1:0]  state_r;
  reg  [7:0]  waddr_r;
  reg         fuse_done_r;
  reg  [31:0] rdata_nxt;
  reg  [39:0] gate_nxt;
  reg  [39:0] free_nxt;
  reg  [5:0]  count_nxt;
  wire [39:0] sensed;
  wire [39:0] in_gated;
  wire [39:0] pd_n;
  wire [39:0] su_n;
  wire [39:0] wu;
  wire [39:0] vw;
  wire        addr_ok;
  integer     i;
  integer     j;
  integer     k;
  genvar      g;

  function [31:0] read_mux;
    input [7:0] a;
    input [31:0] lat;
    begin
      read_mux = 32'h0000_0000;
      case (a)
        `ADDR_PORT0_LATCH:      read_mux = {24'h00_0000, in_gated[7:0]};
        `ADDR_PORT1_LATCH:      read_mux = {24'h00_0000, in_gated[15:8]};
        `ADDR_PORT2_LATCH:      read_mux = {24'h00_0000, in_gated[23:16]};
        `ADDR_PORT3_LATCH:      read_mux = {24'h00_0000, in_gated[31:24]};
        `ADDR_PORT4_LATCH:      read_mux = {24'h00_0000, in_gated[39:32]};
        `ADDR_PORT0_MODE_SEL_A: read_mux = {24'h00_0000, mode_a_r[0]};
        `ADDR_PORT0_MODE_SEL_B: read_mux = {24'h00_0000, mode_b_r[0]};
        `ADDR_PORT1_MODE_SEL_A: read_mux = {24'h00_0000, mode_a_r[1]};
        `ADDR_PORT1_MODE_SEL_B: read_mux = {24'h00_0000, mode_b_r[1]};
        `ADDR_PORT2_MODE_SEL_A: read_mux = {24'h00_0000, mode_a_r[2]};
        `ADDR_PORT2_MODE_SEL_B: read_mux = {24'h00_0000, mode_b_r[2]};
        `ADDR_PORT3_MODE_SEL_A: read_mux = {24'h00_0000, mode_a_r[3]};
        `ADDR_PORT3_MODE_SEL_B: read_mux = {24'h00_0000, mode_b_r[3]};
        `ADDR_PORT4_MODE_SEL_A: read_mux = {24'h00_0000, mode_a_r[4]};
        `ADDR_PORT4_MODE_SEL_B: read_mux = {24'h00_0000, mode_b_r[4]};
        `ADDR_AUX_CONTROL:      read_mux = {24'h00_0000, aux_r};
        `ADDR_LATCH_READBACK:   read_mux = lat;
        `ADDR_IO_STATUS:        read_mux = {26'h000_0000, gpio_count};
        default:                read_mux = 32'h0000_0000;
      endcase
    end
  endfunction

  function [7:0] port_reset_a;
    input [2:0] p;
    input       fuse;
    begin
      case (p)
        3'd0:    port_reset_a = `RST_ALL_ONES;
        3'd4:    port_reset_a = fuse ? (`RST_ALL_ONES & ~`RST_P4_QUASI) : `RST_P4_OPEN_DRAIN;
        default: port_reset_a = fuse ? `RST_ALL_ONES : `RST_ALL_ZEROS;
      endcase
    end
  endfunction

  assign addr_ok = hsel & hready & htrans[1];

  // port drivers, one per 8-bit port
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_port
      pin_driver u_drv (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .latch       (latch_r[g]),
        .mode_a      (mode_a_r[g]),
        .mode_b      (mode_b_r[g]),
        .sensed      (sensed[g*8+7:g*8]),
        .vweak_off   (aux_r[`AUX_WEAK_PULLUP_OFF]),
        .pull_down_n (pd_n[g*8+7:g*8]),
        .strong_up_n (su_n[g*8+7:g*8]),
        .weak_up     (wu[g*8+7:g*8]),
        .vweak_up    (vw[g*8+7:g*8])
      );
    end
  endgenerate

  pin_sync #(
    .WIDTH (40)
  ) u_sync (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .pin_in    (pin_in),
    .level_out (sensed)
  );

  // power-down input gating
  always @* begin
    gate_nxt = {40{1'b1}};
    if (aux_r[`AUX_POWER_DOWN]) begin
      gate_nxt = {40{1'b0}};
      gate_nxt[26] = 1'b1;
      gate_nxt[27] = 1'b1;
      gate_nxt[38] = 1'b1;
      gate_nxt[39] = 1'b1;
      gate_nxt[15:8] = kbd_enable;
    end
  end

  assign in_gated = sensed & gate_nxt;

  // free pin map and count
  always @* begin
    free_nxt  = {40{1'b1}};
    count_nxt = 6'd0;
    if (first_osc_mode != `OSC_INTERNAL_RC) begin
      free_nxt[38] = 1'b0;
      if (first_osc_mode == `OSC_CRYSTAL) begin
        free_nxt[39] = 1'b0;
      end
    end
    if (aux_r[`AUX_SECOND_OSC_ENABLE]) begin
      if (second_osc_pins != 2'd0) begin
        free_nxt[8] = 1'b0;
      end
      if (second_osc_pins == 2'd2) begin
        free_nxt[9] = 1'b0;
      end
    end
    // external memory takes ports 0 and 2 plus four strobe pins
    if (ext_mem_used) begin
      free_nxt[7:0]   = 8'h00;
      free_nxt[23:16] = 8'h00;
      free_nxt[31:30] = 2'b00;
      free_nxt[37:36] = 2'b00;
    end
    for (i = 0; i < 40; i = i + 1) begin
      count_nxt = count_nxt + {5'd0, free_nxt[i]};
    end
  end

  // ahb-lite register slave
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (j = 0; j < 5; j = j + 1) begin
        latch_r[j]  <= `RST_LATCH;
        mode_a_r[j] <= `RST_ALL_ONES;
        mode_b_r[j] <= `RST_ALL_ZEROS;
      end
      mode_b_r[0] <= `RST_ALL_ONES;
      aux_r       <= `RST_AUX;
      state_r     <= ST_IDLE;
      waddr_r     <= 8'h00;
      fuse_done_r <= 1'b0;
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else if (!fuse_done_r) begin
      // strap sampled on the first edge after reset release
      fuse_done_r <= 1'b1;
      for (j = 0; j < 5; j = j + 1) begin
        mode_a_r[j] <= port_reset_a(j[2:0], tristate_fuse);
        mode_b_r[j] <= `RST_ALL_ZEROS;
      end
      mode_b_r[0] <= `RST_ALL_ONES & ~ANALOG_PINS_P0;
      mode_b_r[4] <= `RST_P4_OPEN_DRAIN;
      mode_a_r[0] <= `RST_ALL_ONES | ANALOG_PINS_P0;
      mode_a_r[2] <= port_reset_a(3'd2, tristate_fuse) | ANALOG_PINS_P2;
      mode_b_r[2] <= `RST_ALL_ZEROS;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (addr_ok && hwrite) begin
            waddr_r <= haddr[9:2];
            state_r <= ST_WRITE;
          end else if (addr_ok) begin
            hrdata <= read_mux(haddr[9:2], {latch_r[3], latch_r[2], latch_r[1],
                                            latch_r[0]});
          end
        end
        ST_WRITE: begin
          state_r <= ST_IDLE;
          case (waddr_r)
            `ADDR_PORT0_LATCH:      latch_r[0]  <= hwdata[7:0];
            `ADDR_PORT1_LATCH:      latch_r[1]  <= hwdata[7:0];
            `ADDR_PORT2_LATCH:      latch_r[2]  <= hwdata[7:0];
            `ADDR_PORT3_LATCH:      latch_r[3]  <= hwdata[7:0];
            `ADDR_PORT4_LATCH:      latch_r[4]  <= hwdata[7:0];
            `ADDR_PORT0_MODE_SEL_A: mode_a_r[0] <= hwdata[7:0];
            `ADDR_PORT0_MODE_SEL_B: mode_b_r[0] <= hwdata[7:0];
            `ADDR_PORT1_MODE_SEL_A: mode_a_r[1] <= hwdata[7:0];
            `ADDR_PORT1_MODE_SEL_B: mode_b_r[1] <= hwdata[7:0];
            `ADDR_PORT2_MODE_SEL_A: mode_a_r[2] <= hwdata[7:0];
            `ADDR_PORT2_MODE_SEL_B: mode_b_r[2] <= hwdata[7:0];
            `ADDR_PORT3_MODE_SEL_A: mode_a_r[3] <= hwdata[7:0];
            `ADDR_PORT3_MODE_SEL_B: mode_b_r[3] <= hwdata[7:0];
            `ADDR_PORT4_MODE_SEL_A: mode_a_r[4] <= hwdata[7:0];
            `ADDR_PORT4_MODE_SEL_B: mode_b_r[4] <= hwdata[7:0];
            `ADDR_AUX_CONTROL:      aux_r       <= hwdata[7:0];
            default:                aux_r       <= aux_r;
          endcase
          if (addr_ok && hwrite) begin
            waddr_r <= haddr[9:2];
            state_r <= ST_WRITE;
          end else if (addr_ok) begin
            hrdata <= read_mux(haddr[9:2], {latch_r[3], latch_r[2], latch_r[1],
                                            latch_r[0]});
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // registered pad and alternate-function outputs
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out     <= {40{1'b0}};
      pin_oe_n    <= {40{1'b1}};
      strong_up_n <= {40{1'b1}};
      weak_up     <= {40{1'b0}};
      vweak_up    <= {40{1'b0}};
      alt_in      <= {40{1'b0}};
      gpio_free   <= {40{1'b0}};
      gpio_count  <= 6'd0;
    end else begin
      for (k = 0; k < 40; k = k + 1) begin
        pin_out[k]  <= ~su_n[k] & alt_out[k];
        pin_oe_n[k] <= pd_n[k] & su_n[k];
        // alternate input forced low by a zero latch unless input-only
        alt_in[k]   <= in_gated[k] &
                       (latch_r[k/8][k%8] |
                        ({mode_a_r[k/8][k%8], mode_b_r[k/8][k%8]} == `MODE_INPUT_ONLY));
      end
      strong_up_n <= su_n;
      weak_up     <= wu;
      vweak_up    <= vw;
      gpio_free   <= free_nxt;
      gpio_count  <= count_nxt;
    end
  end
endmodule // io_port_mode_config

// File: rtl/pin_driver.v
`timescale 1ns/10ps
`include "io_port_defines.vh"
// per-pin pad drive decode for one 8-bit port
module pin_driver (
  input  wire       hclk,           // bus clock
  input  wire       hresetn,        // async reset, active low
  input  wire [7:0] latch,          // port data latch
  input  wire [7:0] mode_a,         // mode select a bits
  input  wire [7:0] mode_b,         // mode select b bits
  input  wire [7:0] sensed,         // filtered pin level
  input  wire       vweak_off,      // global very weak pull-up disable
  output reg  [7:0] pull_down_n,    // strong pull-down enable, active low
  output reg  [7:0] strong_up_n,    // strong pull-up enable, active low
  output reg  [7:0] weak_up,        // weak pull-up on
  output reg  [7:0] vweak_up        // very weak pull-up on
);
  reg [7:0] latch_prev_r;
  reg [7:0] pd_nxt;
  reg [7:0] su_nxt;
  reg [7:0] wu_nxt;
  reg [7:0] vw_nxt;
  integer i;

  always @* begin
    pd_nxt = 8'h00;
    su_nxt = 8'h00;
    wu_nxt = 8'h00;
    vw_nxt = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      case ({mode_a[i], mode_b[i]})
        `MODE_QUASI: begin
          pd_nxt[i] = ~latch[i];
          vw_nxt[i] = latch[i] & ~vweak_off;
          wu_nxt[i] = latch[i] & sensed[i];
          su_nxt[i] = latch[i] & ~latch_prev_r[i];
        end
        `MODE_PUSH_PULL: begin
          pd_nxt[i] = ~latch[i];
          su_nxt[i] = latch[i];
        end
        `MODE_OPEN_DRAIN: begin
          pd_nxt[i] = ~latch[i];
        end
        default: begin
          pd_nxt[i] = 1'b0;
        end
      endcase
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_prev_r <= `RST_LATCH;
      pull_down_n  <= 8'hff;
      strong_up_n  <= 8'hff;
      weak_up      <= 8'h00;
      vweak_up     <= 8'h00;
    end else begin
      latch_prev_r <= latch;
      pull_down_n  <= ~pd_nxt;
      strong_up_n  <= ~su_nxt;
      weak_up      <= wu_nxt;
      vweak_up     <= vw_nxt;
    end
  end
endmodule // pin_driver

// File: rtl/pin_sync.v
`timescale 1ns/10ps
// three-stage input sampler; a change is accepted once stages two and three agree
module pin_sync #(
  parameter WIDTH = 8
) (
  input  wire             hclk,     // bus clock
  input  wire             hresetn,  // async reset, active low
  input  wire [WIDTH-1:0] pin_in,   // raw pad level
  output reg  [WIDTH-1:0] level_out // filtered level
);
  reg [WIDTH-1:0] s1_r;
  reg [WIDTH-1:0] s2_r;
  reg [WIDTH-1:0] s3_r;
  integer i;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r      <= {WIDTH{1'b1}};
      s2_r      <= {WIDTH{1'b1}};
      s3_r      <= {WIDTH{1'b1}};
      level_out <= {WIDTH{1'b1}};
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (s2_r[i] == s3_r[i]) begin
          level_out[i] <= s3_r[i];
        end
      end
    end
  end
endmodule // pin_sync
